//--- include/pfs_pkg.sv
/*
 * constants and types for the program flow sequencer: command numbers,
 * command lengths, buffer geometry, loop stack size and servo tick timing.
 * assumes a 100 MHz core clock and 16-bit program buffer words.
 */
package pfs_pkg;
    // =====================================================================
    // clock and servo timing
    // =====================================================================
    localparam int PFS_CLK_MHZ = 100;           // core clock rate in MHz
    localparam int PFS_TICK_US = 120;           // one servo cycle in us
    localparam int PFS_TICK_CYC = PFS_TICK_US * PFS_CLK_MHZ; // cycles per tick

    // =====================================================================
    // buffer geometry
    // =====================================================================
    localparam int PFS_WORD_W = 16;             // program word width
    localparam int PFS_ADDR_W = 8;              // buffer address width
    localparam int PFS_DEPTH = 256;             // buffer words
    localparam int PFS_LOOP_REGS = 8;           // loop registers kept here
    localparam int PFS_LREG_W = 3;              // loop register index width
    localparam int PFS_STACK = 4;               // nesting depth of loops
    localparam int PFS_SP_W = 3;                // stack pointer width
    localparam int PFS_MAXLEN = 8;              // longest command in words

    // =====================================================================
    // command numbers
    // =====================================================================
    localparam logic [15:0] PFS_OP_CLEAR = 16'h0008;  // buffer_clear_cmd
    localparam logic [15:0] PFS_OP_END = 16'h0080;    // end program
    localparam logic [15:0] PFS_OP_DELAY = 16'h008C;  // tick/millisecond delay
    localparam logic [15:0] PFS_OP_LOOP = 16'h00D1;   // loop start
    localparam logic [15:0] PFS_OP_NEXT = 16'h00D2;   // loop_next_cmd, own value
    localparam logic [15:0] PFS_OP_DL = 16'h0009;     // download_begin_cmd, own value
    localparam logic [15:0] PFS_OP_RUN = 16'h000A;    // start program, own value

    // =====================================================================
    // command lengths in words
    // =====================================================================
    localparam logic [3:0] PFS_LEN_ONE = 4'h1;   // end, next, unknown
    localparam logic [3:0] PFS_LEN_DELAY = 4'h3; // delay command
    localparam logic [3:0] PFS_LEN_LOOP = 4'h8;  // loop start command

    // =====================================================================
    // sequencer states
    // =====================================================================
    typedef enum logic [2:0] {
        PFS_HOST,    // host mode, immediate commands only
        PFS_CLEAR,   // erasing the buffer
        PFS_READ,    // buffer address presented
        PFS_GET,     // buffer word captured
        PFS_EXEC,    // whole command gathered
        PFS_WAIT     // wait_for_delay_step
    } pfs_state_t;
endpackage : pfs_pkg

//--- logic/pfs_prog_mem.sv
/*
 * program buffer: single port synchronous ram, a read every cycle plus an optional write.
 * read data comes from a register one cycle after the address.
 */
`timescale 1ns/1ps
module pfs_prog_mem (
    input wire logic clk_in,                                  // core clock
    input wire logic wr_en_in,                                // write strobe
    input wire logic [pfs_pkg::PFS_ADDR_W-1:0] addr_in,       // word address
    input wire logic [pfs_pkg::PFS_WORD_W-1:0] wr_data_in,    // word to write
    output logic [pfs_pkg::PFS_WORD_W-1:0] rd_data_out        // registered read
);
    import pfs_pkg::*;

    // =====================================================================
    // storage
    // =====================================================================
    logic [PFS_WORD_W-1:0] mem_r [PFS_DEPTH];  // buffer words

    // read every cycle, a write returns the old word; no reset so it maps to block ram
    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_r[addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_r[addr_in];
    end
endmodule : pfs_prog_mem

//--- logic/pfs_sequencer.sv
/*
 * program flow sequencer: buffer clear and download, delay counter,
 * end of program and counted loops, running one program thread from the
 * program buffer. the second thread lives elsewhere and only shares the
 * delay counter through its load port. commands and download words come
 * from logic on the same clock, so no synchronisers are used.
 */
`timescale 1ns/1ps
module pfs_sequencer #(
    parameter int TICK_CYC = pfs_pkg::PFS_TICK_CYC          // cycles per servo tick
) (
    input wire logic clk_in,                                 // core clock
    input wire logic rst_in,                                 // sync reset, high
    input wire logic cmd_valid_in,                           // immediate command strobe
    input wire logic [15:0] cmd_op_in,                       // immediate command number
    input wire logic [pfs_pkg::PFS_ADDR_W-1:0] cmd_arg_in,   // start address for run
    input wire logic dl_valid_in,                            // download word strobe
    input wire logic [15:0] dl_word_in,                      // download word
    input wire logic override_in,                            // override command pulse
    input wire logic t2_delay_valid_in,                      // other thread loads counter
    input wire logic [31:0] t2_delay_in,                     // its count, already positive
    input wire logic [pfs_pkg::PFS_LREG_W-1:0] lreg_sel_in,  // loop register to read
    output logic running_out,                                // program mode
    output logic download_out,                               // download open
    output logic busy_out,                                   // buffer erase running
    output logic [pfs_pkg::PFS_ADDR_W-1:0] pc_out,           // program counter
    output logic [31:0] delay_out,                           // delay counter
    output logic [pfs_pkg::PFS_SP_W-1:0] loop_depth_out,     // open loops
    output logic [31:0] lreg_data_out                        // selected loop register
);
    import pfs_pkg::*;

    // =====================================================================
    // helpers
    // =====================================================================
    // words in a command; unknown commands are skipped as one word
    function automatic logic [3:0] op_len(input logic [15:0] op);
        case (op)
            PFS_OP_DELAY: op_len = PFS_LEN_DELAY;
            PFS_OP_LOOP: op_len = PFS_LEN_LOOP;
            default: op_len = PFS_LEN_ONE;
        endcase
    endfunction : op_len

    // two buffer words, high first, form one 32-bit parameter
    function automatic logic [31:0] join32(input logic [15:0] hi, input logic [15:0] lo);
        join32 = {hi, lo};
    endfunction : join32

    // =====================================================================
    // state
    // =====================================================================
    pfs_state_t state_r, state_nxt;             // sequencer state
    logic [PFS_ADDR_W-1:0] pc_r, pc_nxt;        // program counter
    logic [PFS_ADDR_W-1:0] wp_r, wp_nxt;        // buffer write pointer / erase index
    logic dl_r, dl_nxt;                         // download open
    logic [3:0] idx_r, idx_nxt;                 // words gathered so far
    logic [15:0] wbuf_r [PFS_MAXLEN];           // gathered command words
    logic [31:0] delay_r;                       // shared delay counter
    logic [15:0] tick_r;                        // servo tick prescaler
    logic [31:0] lreg_r [PFS_LOOP_REGS];        // loop registers
    logic [PFS_SP_W-1:0] sp_r;                  // loop stack pointer
    logic [PFS_ADDR_W-1:0] stk_body_r [PFS_STACK];  // address after loop start
    logic [31:0] stk_final_r [PFS_STACK];       // final values
    logic [31:0] stk_inc_r [PFS_STACK];         // increments
    logic [PFS_LREG_W-1:0] stk_reg_r [PFS_STACK];   // loop register index
    logic [31:0] lreg_rd_r;                     // registered loop register read
    logic running_r;                            // program mode flag
    logic busy_r;                               // erase in progress flag

    // =====================================================================
    // decode of the gathered command
    // =====================================================================
    wire [15:0] mem_q;                               // buffer read data
    wire [15:0] ex_op = wbuf_r[0];                   // command number
    wire [3:0] ex_len = op_len(ex_op);               // its length
    wire [31:0] p1 = join32(wbuf_r[1], wbuf_r[2]);   // count or initial value
    wire [31:0] p2 = join32(wbuf_r[3], wbuf_r[4]);   // final value
    wire [31:0] p3 = join32(wbuf_r[5], wbuf_r[6]);   // increment
    wire [PFS_LREG_W-1:0] p_reg = wbuf_r[7][PFS_LREG_W-1:0]; // loop register
    wire in_exec = (state_r == PFS_EXEC);            // one cycle per command
    // millisecond and tick delay share a number; no unit handling here
    wire do_delay = in_exec && (ex_op == PFS_OP_DELAY);
    wire do_end = in_exec && (ex_op == PFS_OP_END);
    wire do_loop = in_exec && (ex_op == PFS_OP_LOOP) && (sp_r != PFS_SP_W'(PFS_STACK));
    wire do_next = in_exec && (ex_op == PFS_OP_NEXT) && (sp_r != '0);
    wire delay_neg = p1[31];
    wire delay_pos = !p1[31] && (p1 != '0);
    wire [31:0] delay_mag = delay_neg ? (32'h0 - p1) : p1;
    wire [PFS_SP_W-1:0] top = sp_r - 3'h1;                     // innermost loop
    wire [PFS_LREG_W-1:0] top_reg = stk_reg_r[top[1:0]];
    wire [31:0] top_inc = stk_inc_r[top[1:0]];
    wire [31:0] top_final = stk_final_r[top[1:0]];
    wire [31:0] next_val = lreg_r[top_reg] + top_inc;
    wire next_done = top_inc[31] ? ($signed(next_val) < $signed(top_final))
                                 : ($signed(next_val) > $signed(top_final));
    wire tick = (tick_r == 16'(TICK_CYC - 1));                 // one per servo cycle
    wire host_cmd = cmd_valid_in && (state_r == PFS_HOST);     // immediate accepted
    wire clear_go = host_cmd && (cmd_op_in == PFS_OP_CLEAR);
    wire run_go = host_cmd && (cmd_op_in == PFS_OP_RUN);
    wire dl_go = host_cmd && (cmd_op_in == PFS_OP_DL);
    wire dl_write = dl_r && dl_valid_in && (state_r == PFS_HOST);
    wire erasing = (state_r == PFS_CLEAR);
    wire erase_last = erasing && (wp_r == PFS_ADDR_W'(PFS_DEPTH - 1));
    // erase fills with end commands, so an end follows any loaded program
    wire [15:0] mem_wdata = erasing ? PFS_OP_END : dl_word_in;
    wire mem_we = erasing || dl_write;
    wire [PFS_ADDR_W-1:0] mem_addr = (state_r == PFS_HOST || erasing) ? wp_r : pc_r;

    // =====================================================================
    // program buffer
    // =====================================================================
    pfs_prog_mem u_mem (
        .clk_in(clk_in),
        .wr_en_in(mem_we),
        .addr_in(mem_addr),
        .wr_data_in(mem_wdata),
        .rd_data_out(mem_q)
    );

    // =====================================================================
    // next state
    // =====================================================================
    // one command executes per exec cycle; override wins in every state except host mode and a buffer erase
    always_comb begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        wp_nxt = wp_r;
        dl_nxt = dl_r;
        idx_nxt = idx_r;
        case (state_r)
            PFS_HOST: begin
                // end in host mode falls here and is simply dropped
                if (clear_go) begin
                    state_nxt = PFS_CLEAR;
                    wp_nxt = '0;
                    dl_nxt = 1'b0;                   // clear closes download
                end else if (dl_go) begin
                    dl_nxt = 1'b1;
                end else if (run_go) begin
                    dl_nxt = 1'b0;
                    pc_nxt = cmd_arg_in;
                    idx_nxt = '0;
                    state_nxt = PFS_READ;
                end else if (dl_write) begin
                    wp_nxt = wp_r + 8'h1;
                end
            end
            PFS_CLEAR: begin
                // erase every word first, then rewind the pointer
                wp_nxt = erase_last ? '0 : wp_r + 8'h1;
                if (erase_last) begin
                    state_nxt = PFS_HOST;
                end
            end
            PFS_READ: state_nxt = PFS_GET;
            PFS_GET: begin
                pc_nxt = pc_r + 8'h1;
                idx_nxt = idx_r + 4'h1;
                // first word sets the length through the op in mem_q
                if ((idx_r == '0 && op_len(mem_q) == PFS_LEN_ONE) ||
                    (idx_r != '0 && idx_r == ex_len - 4'h1)) begin
                    state_nxt = PFS_EXEC;
                end else begin
                    state_nxt = PFS_READ;
                end
            end
            PFS_EXEC: begin
                idx_nxt = '0;
                state_nxt = PFS_READ;
                if (do_end) begin
                    state_nxt = PFS_HOST;
                end else if (do_delay && delay_pos) begin
                    state_nxt = PFS_WAIT;
                end else if (do_next && !next_done) begin
                    pc_nxt = stk_body_r[top[1:0]];
                end
            end
            PFS_WAIT: begin
                if (delay_r == '0) begin
                    state_nxt = PFS_READ;
                end
            end
            default: state_nxt = PFS_HOST;
        endcase
        if (override_in && state_r != PFS_HOST && !erasing) begin
            state_nxt = PFS_HOST;
        end
    end

    // =====================================================================
    // sequencer registers
    // =====================================================================
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_r <= PFS_HOST;
            pc_r <= '0;
            wp_r <= '0;
            dl_r <= 1'b0;
            idx_r <= '0;
            running_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            wp_r <= wp_nxt;
            dl_r <= dl_nxt;
            idx_r <= idx_nxt;
            // flags follow the next state so pins track state_r with no lag
            running_r <= (state_nxt != PFS_HOST) && (state_nxt != PFS_CLEAR);
            busy_r <= (state_nxt == PFS_CLEAR);
        end
    end

    // capture each buffer word into its slot
    always_ff @(posedge clk_in) begin
        if (state_r == PFS_GET) begin
            wbuf_r[idx_r[2:0]] <= mem_q;
        end
    end

    // =====================================================================
    // servo tick and shared delay counter
    // =====================================================================
    // prescaler free-runs so tick spacing is exact regardless of loads
    always_ff @(posedge clk_in) begin
        if (rst_in || tick) begin
            tick_r <= '0;
        end else begin
            tick_r <= tick_r + 16'h1;
        end
    end

    // a load from either thread replaces the count; ours wins a tie
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            delay_r <= '0;
        end else if (do_delay) begin
            delay_r <= delay_mag;
        end else if (t2_delay_valid_in) begin
            delay_r <= t2_delay_in;
        end else if (tick && delay_r != '0) begin
            delay_r <= delay_r - 32'h1;
        end
    end

    // =====================================================================
    // loop stack and loop registers
    // =====================================================================
    // loop start pushes, a finished next pops; registers have no reset
    always_ff @(posedge clk_in) begin
        if (rst_in || state_r == PFS_HOST) begin
            sp_r <= '0;
        end else if (do_loop) begin
            sp_r <= sp_r + 3'h1;
        end else if (do_next && next_done) begin
            sp_r <= sp_r - 3'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (do_loop) begin
            lreg_r[p_reg] <= p1;
            stk_body_r[sp_r[1:0]] <= pc_r;
            stk_final_r[sp_r[1:0]] <= p2;
            stk_inc_r[sp_r[1:0]] <= p3;
            stk_reg_r[sp_r[1:0]] <= p_reg;
        end else if (do_next) begin
            lreg_r[top_reg] <= next_val;
        end
        lreg_rd_r <= lreg_r[lreg_sel_in];
    end

    // =====================================================================
    // outputs
    // =====================================================================
    assign running_out = running_r;
    assign download_out = dl_r;
    assign busy_out = busy_r;
    assign pc_out = pc_r;
    assign delay_out = delay_r;
    assign loop_depth_out = sp_r;
    assign lreg_data_out = lreg_rd_r;

    // =====================================================================
    // checks
    // =====================================================================
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_clear_erase: assert property (clear_go |=> busy_out [*8])
        else $error("erase did not start");
    a_clear_rewind: assert property ($fell(busy_out) |-> wp_r == '0 && !dl_r)
        else $error("pointer not rewound");
    a_clear_closes: assert property (dl_r && clear_go |=> !download_out)
        else $error("download still open");
    a_delay_load: assert property (do_delay |=> delay_r == $past(delay_mag))
        else $error("delay not loaded");
    a_delay_dec: assert property (tick && delay_r != '0 && !do_delay && !t2_delay_valid_in
        |=> delay_r == $past(delay_r) - 32'h1)
        else $error("delay not decremented");
    a_delay_wait: assert property (do_delay && delay_pos && !override_in
        |=> state_r == PFS_WAIT)
        else $error("positive delay did not wait");
    a_delay_skip: assert property (do_delay && delay_neg && !override_in
        |=> state_r == PFS_READ)
        else $error("negative delay waited");
    a_end_host: assert property (do_end |=> !running_out)
        else $error("end did not stop");
    a_end_idle: assert property (host_cmd && cmd_op_in == PFS_OP_END && !dl_r
        |=> state_r == PFS_HOST && $stable(pc_r))
        else $error("end in host mode acted");
    a_override: assert property (override_in && running_out |=> !running_out)
        else $error("override ignored");
    a_loop_push: assert property (do_loop |=> sp_r == $past(sp_r) + 3'h1)
        else $error("loop not opened");
    a_loop_back: assert property (do_next && !next_done && !override_in
        |=> pc_r == $past(stk_body_r[top[1:0]]))
        else $error("loop did not repeat");
    a_wait_hold: assert property (state_r == PFS_WAIT && delay_r != '0 && !override_in
        |=> state_r == PFS_WAIT)
        else $error("wait released early");

    c_clear: cover property (clear_go ##1 busy_out [*4]);
    c_wait: cover property (state_r == PFS_WAIT ##1 state_r == PFS_READ);
    c_loop_end: cover property (do_next && next_done);
    c_override: cover property (override_in && running_out);
endmodule : pfs_sequencer

//--- testbench/pfs_host_model.sv
/*
 * host side model: sends immediate commands, download words and override
 * pulses to the sequencer on behalf of the testbench.
 * assumes the caller only sends a clear while the sequencer is in host mode.
 */
`timescale 1ns/1ps
module pfs_host_model (
    input wire logic clk_in,              // core clock
    output logic cmd_valid_out,           // command strobe
    output logic [15:0] cmd_op_out,       // command number
    output logic [7:0] cmd_arg_out,       // run start address
    output logic dl_valid_out,            // download strobe
    output logic [15:0] dl_word_out,      // download word
    output logic override_out             // override pulse
);
    // ======================================================
    // idle levels
    // ======================================================
    initial begin
        cmd_valid_out = 1'b0;
        cmd_op_out = 16'h0000;
        cmd_arg_out = 8'h00;
        dl_valid_out = 1'b0;
        dl_word_out = 16'h0000;
        override_out = 1'b0;
    end
    // one-cycle command strobe; clear only from host mode
    task send_cmd(input logic [15:0] op, input logic [7:0] arg);
        @(posedge clk_in);
        cmd_valid_out <= 1'b1;
        cmd_op_out <= op;
        cmd_arg_out <= arg;
        @(posedge clk_in);
        cmd_valid_out <= 1'b0;
        cmd_op_out <= ~op; // released lines do not hold the old value
    endtask : send_cmd
    task send_word(input logic [15:0] w);
        @(posedge clk_in);
        dl_valid_out <= 1'b1;
        dl_word_out <= w;
        @(posedge clk_in);
        dl_valid_out <= 1'b0;
        dl_word_out <= ~w;
    endtask : send_word
    task pulse_override();
        @(posedge clk_in);
        override_out <= 1'b1;
        @(posedge clk_in);
        override_out <= 1'b0;
    endtask : pulse_override
endmodule : pfs_host_model

//--- testbench/tb_top.sv
/*
 * self-checking bench for the sequencer with a shortened servo tick.
 * assumes the host model file is compiled first.
 */
`timescale 1ns/1ps
module tb_top;
    import pfs_pkg::*;
    // ======================================================
    // clock, reset, wiring
    // ======================================================
    logic clk_in = 1'b0; // core clock
    logic rst_in = 1'b1; // sync reset
    logic t2_v = 1'b0; // thread two load
    logic [31:0] t2_d = 32'h0; // its count
    logic [2:0] sel = 3'h0; // loop register select
    logic cv, dv, ov, run, dlo, busy;
    logic [15:0] cop, dw;
    logic [7:0] carg, pc;
    logic [31:0] dly, lr;
    logic [2:0] depth;
    int error_cnt = 0;
    int num_checks = 0;
    int i;
    // loops nest: outer reg1 0..1 inc 1, inner reg2 3..0 inc -1; delay program at 22
    localparam logic [15:0] PROG [25] = '{16'h008C, 16'hFFFF, 16'hFFFB,
        16'h00D1, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0001,
        16'h00D1, 16'h0000, 16'h0003, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0002,
        16'h00D2, 16'h00D2, 16'h0080, 16'h008C, 16'h0000, 16'h0002};
    always #5 clk_in = ~clk_in;
    pfs_host_model host_u (.clk_in(clk_in), .cmd_valid_out(cv), .cmd_op_out(cop),
        .cmd_arg_out(carg), .dl_valid_out(dv), .dl_word_out(dw), .override_out(ov));
    pfs_sequencer #(.TICK_CYC(10)) dut_u (.clk_in(clk_in), .rst_in(rst_in),
        .cmd_valid_in(cv), .cmd_op_in(cop), .cmd_arg_in(carg), .dl_valid_in(dv),
        .dl_word_in(dw), .override_in(ov), .t2_delay_valid_in(t2_v), .t2_delay_in(t2_d),
        .lreg_sel_in(sel), .running_out(run), .download_out(dlo), .busy_out(busy),
        .pc_out(pc), .delay_out(dly), .loop_depth_out(depth), .lreg_data_out(lr));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    task clear_and_load();
        host_u.send_cmd(PFS_OP_DL, 8'h00);
        host_u.send_cmd(PFS_OP_CLEAR, 8'h00);
        #1 check(32'({busy, dlo}), 32'h2);
        for (i = 0; busy === 1'b1 && i < 400; i++) @(posedge clk_in) #1;
        check(i, 256);
        host_u.send_cmd(PFS_OP_DL, 8'h00);
        for (i = 0; i < 25; i++) host_u.send_word(PROG[i]);
    endtask : clear_and_load
    task loops_run();
        host_u.send_cmd(PFS_OP_RUN, 8'h00);
        for (i = 0; depth !== 3'h1 && i < 100; i++) @(posedge clk_in) #1;
        check(32'(depth), 32'h1);
        check(32'(dly >= 1 && dly <= 5), 32'h1);
        for (i = 0; run !== 1'b0 && i < 800; i++) @(posedge clk_in) #1;
        check(32'(run), 32'h0);
        check(32'(pc), 32'h16);
        @(posedge clk_in);
        sel <= 3'h1;
        repeat (2) @(posedge clk_in);
        #1 check(lr, 32'h2);
        @(posedge clk_in);
        sel <= 3'h2;
        repeat (2) @(posedge clk_in);
        #1 check(lr, 32'hFFFFFFFF);
    endtask : loops_run
    task delay_run(input logic stop);
        host_u.send_cmd(PFS_OP_RUN, 8'h16);
        for (i = 0; dly !== 32'h2 && i < 30; i++) @(posedge clk_in) #1;
        check(dly, 32'h2);
        check(32'(run), 32'h1);
        if (stop) begin
            host_u.pulse_override();
            repeat (2) @(posedge clk_in);
            #1 check(32'(run), 32'h0);
        end else begin
            for (i = 0; run !== 1'b0 && i < 60; i++) @(posedge clk_in) #1;
            check(32'(i >= 11 && i <= 26), 32'h1);
            check(32'(run), 32'h0);
            check(dly, 32'h0);
        end
    endtask : delay_run
    // end in host mode must leave pc alone; thread two then reloads the counter
    task host_idle_run();
        host_u.send_cmd(PFS_OP_END, 8'h00);
        #1 check(32'(run), 32'h0);
        check(32'(pc), 32'h19);
        @(posedge clk_in);
        t2_v <= 1'b1;
        t2_d <= 32'h7;
        @(posedge clk_in);
        t2_v <= 1'b0;
        #1 check(dly, 32'h7);
    endtask : host_idle_run
    initial begin
        #200000;
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        #1 check(32'({run, dlo, busy}), 32'h0);
        check(dly, 32'h0);
        check(32'(depth), 32'h0);
        clear_and_load();
        loops_run();
        delay_run(1'b0);
        delay_run(1'b1);
        host_idle_run();
        complete_run();
    end
endmodule : tb_top
